// [hdl/cfg_serial_map.svh]
/*
 Constants of the two-wire configuration port: slave address, register
 locations, reset values and bit counts.
 Assumes it is included by bare name by the package and the port module.
*/
`ifndef CFG_SERIAL_MAP_SVH
`define CFG_SERIAL_MAP_SVH

`define CFG_SLAVE_ADDR 7'h10
`define CFG_GENCALL_ADDR 7'h00
`define CFG_LOC_BITS 4
`define CFG_REG_COUNT 16
`define CFG_SYSTEM_CONFIG_IDX 4'h0
`define CFG_DLY_A_IDX 4'h1
`define CFG_DLY_B_IDX 4'h2
`define CFG_SYSTEM_CONFIG_RST 8'h06
`define CFG_DLY_A_RST 8'h00
`define CFG_DLY_B_RST 8'h00
`define CFG_OTHER_RST 8'h00
`define CFG_CELL_LSB 0
`define CFG_CELL_MSB 2
`define CFG_BYTE_BITS 4'h8
`define CFG_RW_READ 1'b1

`endif

// [hdl/cfg_serial_pkg.sv]
/*
 Types of the two-wire configuration port.
 Assumes cfg_serial_map.svh is on the include path.
*/
package cfg_serial_pkg;
   `include "cfg_serial_map.svh"

   typedef enum logic [3:0] {
      IDLE, ADDR, ADDR_ACK, LOC, LOC_ACK, WDATA, WDATA_ACK, RDATA, RDATA_ACK
   } port_state_t;

   // four detection delay codes, one nibble each
   typedef struct packed {
      logic [3:0] overVoltage;
      logic [3:0] underVoltage;
      logic [3:0] overCurrent;
      logic [3:0] shortCircuit;
   } delay_set_t;
endpackage : cfg_serial_pkg

// [hdl/config_serial_slave_port.sv]
/*
 Two-wire slave configuration port with its register array, the cell count
 field and the delay-zero selection of detection delays.
 Assumes the master drives the serial clock; pins arrive asynchronously and
 the bus wires are resolved outside from the output enable.
*/
// Notes on behaviour
// - only the 7-bit address 0010000 is acknowledged, all others are ignored.
// - the port is always a slave and never drives the serial clock.
// - the general call address is neither acknowledged nor acted upon.
// - the location never advances between data bytes.
// - the last location is kept so later reads need not resend it.
// - data and clock use separate pins and data is sampled on clock edges.
// - with delay-zero select low the stored detection delays apply.
// - with delay-zero select high every detection delay is forced to minimum.
// - the serial port works only while delay-zero select is high.
// - the cell count comes from a three-bit field of the system config register.
`timescale 1ns/10ps
`include "cfg_serial_map.svh"

module config_serial_slave_port
   import cfg_serial_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic serialClockIn,
   input wire logic serialDataPinIn,
   output logic serialDataPinOut,
   output logic serialDataPinOe,
   input wire logic delayZeroSelect,
   output logic [2:0] cellCountSelect,
   output delay_set_t effectiveDelay
);

   logic sclS1_r, sclS2_r, sclS3_r;
   logic sdaS1_r, sdaS2_r, sdaS3_r;
   logic dzsS1_r, dzsS2_r;
   logic sclRise, sclFall, startEv, stopEv, portEn;
   port_state_t state_r;
   logic [3:0] bitCnt_r;
   logic [7:0] shift_r;
   logic [7:0] tx_r;
   logic [`CFG_LOC_BITS-1:0] loc_r;
   logic locValid_r;
   logic rw_r;
   logic masterNack_r;
   logic [7:0] regs_r [`CFG_REG_COUNT];
   logic byteDone, addrHit;
   delay_set_t storedDelay;
   delay_set_t effDelay_r;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sclS1_r <= 1'b1;
         sclS2_r <= 1'b1;
         sclS3_r <= 1'b1;
         sdaS1_r <= 1'b1;
         sdaS2_r <= 1'b1;
         sdaS3_r <= 1'b1;
      end else begin
         sclS1_r <= serialClockIn;
         sclS2_r <= sclS1_r;
         sclS3_r <= sclS2_r;
         sdaS1_r <= serialDataPinIn;
         sdaS2_r <= sdaS1_r;
         sdaS3_r <= sdaS2_r;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         dzsS1_r <= 1'b0;
         dzsS2_r <= 1'b0;
      end else begin
         dzsS1_r <= delayZeroSelect;
         dzsS2_r <= dzsS1_r;
      end
   end

   assign sclRise = sclS2_r & ~sclS3_r;
   assign sclFall = ~sclS2_r & sclS3_r;
   assign startEv = sclS2_r & sclS3_r & ~sdaS2_r & sdaS3_r;
   assign stopEv = sclS2_r & sclS3_r & sdaS2_r & ~sdaS3_r;
   // port open only while select is high
   assign portEn = dzsS2_r;
   assign byteDone = (bitCnt_r == `CFG_BYTE_BITS);
   assign addrHit = (shift_r[7:1] == `CFG_SLAVE_ADDR) &&
                    (shift_r[7:1] != `CFG_GENCALL_ADDR);

   // bit counter and receive shifter, sampled on clock rise
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bitCnt_r <= 4'h0;
         shift_r <= 8'h00;
      end else if (!portEn || startEv) begin
         bitCnt_r <= 4'h0;
      end else if (sclFall && byteDone) begin
         bitCnt_r <= 4'h0;
      end else if (sclRise && (state_r == ADDR || state_r == LOC ||
                               state_r == WDATA || state_r == RDATA)) begin
         bitCnt_r <= bitCnt_r + 4'h1;
         shift_r <= {shift_r[6:0], sdaS2_r};
      end
   end

   // transaction sequencer, moves on clock fall
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_r <= IDLE;
         rw_r <= 1'b0;
      end else if (!portEn) begin
         state_r <= IDLE;
      end else if (startEv) begin
         state_r <= ADDR;
      end else if (stopEv) begin
         state_r <= IDLE;
      end else if (sclFall) begin
         unique case (state_r)
            IDLE: state_r <= IDLE;
            ADDR: begin
               if (byteDone) begin
                  // foreign address drops back to idle
                  state_r <= addrHit ? ADDR_ACK : IDLE;
                  rw_r <= shift_r[0];
               end
            end
            ADDR_ACK: begin
               state_r <= (rw_r == `CFG_RW_READ) ? RDATA : LOC;
            end
            LOC: begin
               if (byteDone)
                  state_r <= LOC_ACK;
            end
            LOC_ACK: state_r <= WDATA;
            WDATA: begin
               if (byteDone)
                  state_r <= WDATA_ACK;
            end
            // next byte goes to the same place
            WDATA_ACK: state_r <= WDATA;
            RDATA: begin
               if (byteDone)
                  state_r <= RDATA_ACK;
            end
            RDATA_ACK: state_r <= masterNack_r ? IDLE : RDATA;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         loc_r <= '0;
         locValid_r <= 1'b0;
      end else if (portEn && sclFall && state_r == LOC && byteDone) begin
         loc_r <= shift_r[`CFG_LOC_BITS-1:0];
         locValid_r <= (shift_r[7:`CFG_LOC_BITS] == '0);
      end
   end

   // master answer after each read byte
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         masterNack_r <= 1'b0;
      else if (sclRise && state_r == RDATA_ACK)
         masterNack_r <= sdaS2_r;
   end

   // register array; writes go to the held location only
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < `CFG_REG_COUNT; i++)
            regs_r[i] <= `CFG_OTHER_RST;
         regs_r[`CFG_SYSTEM_CONFIG_IDX] <= `CFG_SYSTEM_CONFIG_RST;
         regs_r[`CFG_DLY_A_IDX] <= `CFG_DLY_A_RST;
         regs_r[`CFG_DLY_B_IDX] <= `CFG_DLY_B_RST;
      end else if (portEn && sclFall && state_r == WDATA && byteDone && locValid_r) begin
         regs_r[loc_r] <= shift_r;
      end
   end

   // transmit shifter, loaded and shifted on clock fall
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tx_r <= 8'hFF;
      end else if (!portEn || startEv || stopEv) begin
         tx_r <= 8'hFF;
      end else if (sclFall) begin
         if ((state_r == ADDR_ACK && rw_r == `CFG_RW_READ) ||
             (state_r == RDATA_ACK && !masterNack_r))
            tx_r <= locValid_r ? regs_r[loc_r] : 8'h00;
         else if (state_r == RDATA && !byteDone)
            tx_r <= {tx_r[6:0], 1'b1};
         else
            tx_r <= 8'hFF;
      end
   end

   // only the data line is ever pulled; there is no clock output
   assign serialDataPinOut = 1'b0;
   assign serialDataPinOe = (state_r == ADDR_ACK) || (state_r == LOC_ACK) ||
                            (state_r == WDATA_ACK) || (state_r == RDATA && !tx_r[7]);

   assign cellCountSelect = regs_r[`CFG_SYSTEM_CONFIG_IDX][`CFG_CELL_MSB:`CFG_CELL_LSB];
   assign storedDelay = {regs_r[`CFG_DLY_A_IDX], regs_r[`CFG_DLY_B_IDX]};

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         effDelay_r <= '0;
      else
         effDelay_r <= dzsS2_r ? delay_set_t'('0) : storedDelay;
   end
   assign effectiveDelay = effDelay_r;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   property p_addr_ignore;
      state_r == ADDR && sclFall && byteDone && portEn && !startEv && !stopEv &&
         shift_r[7:1] != `CFG_SLAVE_ADDR |=> state_r == IDLE ##1 !serialDataPinOe;
   endproperty
   a_addr_ignore: assert property (p_addr_ignore) else $error("foreign address acked");

   property p_gencall;
      state_r == ADDR && sclFall && byteDone && portEn && !startEv && !stopEv &&
         shift_r[7:1] == `CFG_GENCALL_ADDR |=> state_r != ADDR_ACK;
   endproperty
   a_gencall: assert property (p_gencall) else $error("general call acked");

   property p_drive_low;
      serialDataPinOe |-> serialDataPinOut == 1'b0;
   endproperty
   a_drive_low: assert property (p_drive_low) else $error("data driven high");

   property p_change_on_low;
      $changed(serialDataPinOe) && $past(portEn) && !$past(startEv) && !$past(stopEv)
         |-> !sclS2_r;
   endproperty
   a_change_on_low: assert property (p_change_on_low) else $error("data moved with clock high");

   property p_no_incr;
      state_r == WDATA_ACK && sclFall && portEn && !startEv && !stopEv
         |=> state_r == WDATA && $stable(loc_r);
   endproperty
   a_no_incr: assert property (p_no_incr) else $error("location advanced");

   property p_loc_held;
      !(portEn && sclFall && state_r == LOC && byteDone) |=> $stable(loc_r);
   endproperty
   a_loc_held: assert property (p_loc_held) else $error("location lost");

   property p_stored_delay;
      !dzsS2_r |=> effDelay_r == $past(storedDelay);
   endproperty
   a_stored_delay: assert property (p_stored_delay) else $error("stored delay not used");

   property p_min_delay;
      dzsS2_r [*2] |-> effDelay_r == '0;
   endproperty
   a_min_delay: assert property (p_min_delay) else $error("delay not minimum");

   property p_port_closed;
      !dzsS2_r |=> state_r == IDLE && !serialDataPinOe;
   endproperty
   a_port_closed: assert property (p_port_closed) else $error("port active while closed");

   property p_direction;
      state_r == ADDR_ACK && sclFall && portEn && !startEv && !stopEv
         |=> state_r == (rw_r ? RDATA : LOC);
   endproperty
   a_direction: assert property (p_direction) else $error("wrong direction");

   property p_write_lands;
      portEn && sclFall && state_r == WDATA && byteDone && locValid_r
         |=> regs_r[loc_r] == $past(shift_r);
   endproperty
   a_write_lands: assert property (p_write_lands) else $error("data byte not stored");

   property p_cell_count;
      portEn && sclFall && state_r == WDATA && byteDone && locValid_r &&
         loc_r == `CFG_SYSTEM_CONFIG_IDX
         |=> cellCountSelect == $past(shift_r[`CFG_CELL_MSB:`CFG_CELL_LSB]);
   endproperty
   a_cell_count: assert property (p_cell_count) else $error("cell count not taken");

   property p_read_first_bit;
      state_r == ADDR_ACK && rw_r == `CFG_RW_READ && sclFall && portEn && !startEv && !stopEv
         |=> serialDataPinOe == (locValid_r ? !regs_r[loc_r][7] : 1'b1);
   endproperty
   a_read_first_bit: assert property (p_read_first_bit) else $error("read not from kept place");

   property p_closed_no_write;
      !portEn |=> $stable(cellCountSelect) && $stable(storedDelay);
   endproperty
   a_closed_no_write: assert property (p_closed_no_write) else $error("write while closed");

endmodule : config_serial_slave_port

// [dv/two_wire_master_model.sv]
/*
 Behavioural two-wire bus master that clocks and sequences every frame.
 Assumes a pull-up on the data wire, and that the caller enters each task
 just after a rising edge of the system clock. One bus bit takes 8 clocks.
*/
`timescale 1ns/10ps

module two_wire_master_model (
   input wire logic clock,
   input wire logic sdaWire,
   output logic sclOut,
   output logic sdaPull
);
   initial begin
      sclOut = 1'b1;
      sdaPull = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask : tick

   task automatic busBit(input logic b, output logic r);
      sclOut <= 1'b0;
      tick(2);
      sdaPull <= !b;
      tick(2);
      sclOut <= 1'b1;
      tick(2);
      @(negedge clock);
      r = sdaWire;
      tick(2);
   endtask : busBit

   // clock stays high between frames
   task automatic start();
      sclOut <= 1'b0;
      tick(2);
      sdaPull <= 1'b0;
      tick(2);
      sclOut <= 1'b1;
      tick(4);
      sdaPull <= 1'b1;
      tick(4);
   endtask : start

   task automatic stop();
      sclOut <= 1'b0;
      tick(2);
      sdaPull <= 1'b1;
      tick(2);
      sclOut <= 1'b1;
      tick(4);
      sdaPull <= 1'b0;
      tick(4);
   endtask : stop

   // send d msb first (FF to listen), then the ninth bit
   task automatic xfer(input logic [7:0] d, input logic ninth, output logic [7:0] r,
                       output logic ackBit);
      for (int i = 7; i >= 0; i--) begin
         busBit(d[i], r[i]);
      end
      busBit(ninth, ackBit);
   endtask : xfer
endmodule : two_wire_master_model

// [dv/config_serial_slave_port_tb.sv]
/*
 Self-checking bench of the two-wire configuration port.
 Assumes the master model drives the bus clock and the resolved data wire.
*/
`timescale 1ns/10ps
`include "cfg_serial_map.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin numErrors++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp); end end

module config_serial_slave_port_tb;
   import cfg_serial_pkg::*;

   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic delayZeroSelect = 1'b0;
   logic sclOut;
   logic sdaPull;
   logic serialDataPinOut;
   logic serialDataPinOe;
   logic [2:0] cellCountSelect;
   delay_set_t effectiveDelay;
   wire sdaWire = !(sdaPull || (serialDataPinOe && !serialDataPinOut));
   int numErrors = 0;
   int comparisons = 0;
   logic [7:0] rd;
   logic ack;
   logic [7:0] wAddr = {`CFG_SLAVE_ADDR, 1'b0};
   logic [7:0] rAddr = {`CFG_SLAVE_ADDR, `CFG_RW_READ};

   always #25 clock = ~clock;

   config_serial_slave_port i_dut (
      .clock(clock), .rstn(rstn), .serialClockIn(sclOut), .serialDataPinIn(sdaWire),
      .serialDataPinOut(serialDataPinOut), .serialDataPinOe(serialDataPinOe),
      .delayZeroSelect(delayZeroSelect), .cellCountSelect(cellCountSelect),
      .effectiveDelay(effectiveDelay)
   );

   two_wire_master_model i_master (
      .clock(clock), .sdaWire(sdaWire), .sclOut(sclOut), .sdaPull(sdaPull)
   );

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, numErrors);
      if (numErrors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results

   // one write frame; ack of the address byte comes back
   task automatic wrFrame(input logic [7:0] a, input logic [7:0] loc, input logic [7:0] d,
                          output logic addrAck);
      logic dummy;
      i_master.start();
      i_master.xfer(a, 1'b1, rd, addrAck);
      i_master.xfer(loc, 1'b1, rd, dummy);
      i_master.xfer(d, 1'b1, rd, dummy);
      i_master.stop();
   endtask : wrFrame

   task automatic t_reset();
      i_master.tick(4);
      `CHK(cellCountSelect, 3'h6)
      `CHK(effectiveDelay, delay_set_t'(16'h0000))
      $display("reset test done");
   endtask : t_reset

   task automatic t_closed();
      wrFrame(wAddr, 8'h00, 8'h01, ack);
      `CHK(ack, 1'b1)
      `CHK(cellCountSelect, 3'h6)
      $display("closed port test done");
   endtask : t_closed

   task automatic t_write();
      delayZeroSelect <= 1'b1;
      i_master.tick(6);
      i_master.start();
      i_master.xfer(wAddr, 1'b1, rd, ack);
      `CHK(ack, 1'b0)
      i_master.xfer(8'h00, 1'b1, rd, ack);
      i_master.xfer(8'h03, 1'b1, rd, ack);
      i_master.xfer(8'h05, 1'b1, rd, ack);
      `CHK(ack, 1'b0)
      i_master.stop();
      `CHK(cellCountSelect, 3'h5)
      wrFrame(wAddr, 8'h01, 8'hA5, ack);
      wrFrame(wAddr, 8'h02, 8'h3C, ack);
      $display("write test done");
   endtask : t_write

   task automatic t_read();
      i_master.start();
      i_master.xfer(rAddr, 1'b1, rd, ack);
      `CHK(ack, 1'b0)
      i_master.xfer(8'hFF, 1'b0, rd, ack);
      `CHK(rd, 8'h3C)
      i_master.xfer(8'hFF, 1'b1, rd, ack);
      `CHK(rd, 8'h3C)
      i_master.stop();
      $display("read test done");
   endtask : t_read

   task automatic t_foreign();
      wrFrame({`CFG_GENCALL_ADDR, 1'b0}, 8'h00, 8'h07, ack);
      `CHK(ack, 1'b1)
      wrFrame(8'h22, 8'h00, 8'h07, ack);
      `CHK(ack, 1'b1)
      `CHK(cellCountSelect, 3'h5)
      wrFrame(wAddr, 8'h10, 8'h07, ack);
      `CHK(ack, 1'b0)
      `CHK(cellCountSelect, 3'h5)
      i_master.start();
      i_master.xfer(rAddr, 1'b1, rd, ack);
      i_master.xfer(8'hFF, 1'b1, rd, ack);
      `CHK(rd, 8'h00)
      i_master.stop();
      $display("foreign address test done");
   endtask : t_foreign

   task automatic t_delay();
      `CHK(effectiveDelay, delay_set_t'(16'h0000))
      delayZeroSelect <= 1'b0;
      i_master.tick(6);
      `CHK(effectiveDelay, delay_set_t'(16'hA53C))
      $display("delay select test done");
   endtask : t_delay

   initial begin
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      t_reset();
      t_closed();
      t_write();
      t_read();
      t_foreign();
      t_delay();
      results();
   end

   // hang guard
   initial begin
      repeat (20000) @(posedge clock);
      numErrors++;
      results();
   end
endmodule : config_serial_slave_port_tb
